// >>> core/sram_link_params.svh
`ifndef SRAM_LINK_PARAMS_SVH
`define SRAM_LINK_PARAMS_SVH

// Word address width, one address per data word of a burst
`define LINK_ADDR_W    23
// Data word width on both data ports
`define LINK_WORD_W    18
// Width of one byte lane governed by one byte write select
`define LINK_BYTE_W    9
// Byte lanes per data word
`define LINK_BYTE_CNT  2
// Words per burst
`define LINK_BURST_LEN 4
// Data edges from the starting positive rise to the first write word
`define LINK_WR_FIRST  2
// Data edges from the starting positive rise to the first read word (2.5 cycles)
`define LINK_RD_FIRST  5
// Depth of the per-edge transaction pipeline
`define LINK_PIPE_LEN  9
// Entries of the command buffer in front of the controller
`define LINK_BUF_DEPTH 2

`endif

// >>> core/sram_link_pkg.sv
package sram_link_pkg;

  // Input clock pair state as made by the controller
  typedef enum logic [1:0] {
    LINK_PARKED = 2'b00,
    LINK_RUN    = 2'b01
  } link_state_t;

endpackage

// >>> core/sram_link_if.sv
`timescale 1ns/1ps
`include "sram_link_params.svh"

interface sram_link_if #(
  parameter int ADDR_W   = `LINK_ADDR_W,
  parameter int WORD_W   = `LINK_WORD_W,
  parameter int BYTE_CNT = `LINK_BYTE_CNT
);
  // Positive and negative input clocks, each sampled as a level
  logic                k;
  logic                k_n;
  // Shared address, latched on rises of both input clocks
  logic [ADDR_W-1:0]   addr;
  // Port selects, active low
  logic                read_port_select_n;
  logic                write_port_select_n;
  // Write data and byte write selects, active low
  logic [WORD_W-1:0]   d;
  logic [BYTE_CNT-1:0] byte_write_select_n;
  // Read data and its output enable, low while driven
  logic [WORD_W-1:0]   q;
  logic                q_oe_n;

  // Memory end
  modport dev (
    input  k, k_n, addr, read_port_select_n, write_port_select_n, d, byte_write_select_n,
    output q, q_oe_n
  );

  // Controller end
  modport ctrl (
    output k, k_n, addr, read_port_select_n, write_port_select_n, d, byte_write_select_n,
    input  q, q_oe_n
  );
endinterface

// >>> core/burst_buffer.sv
`timescale 1ns/1ps
`include "sram_link_params.svh"

module burst_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `LINK_BUF_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Entry storage and pointers
  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;

  // Handshake decode
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = slot_reg[rd_ptr_reg];

  // Pointer wrap helper
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop) rd_ptr_reg <= bump(rd_ptr_reg);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Entry write
  always_ff @(posedge sys_clk) begin
    if (push) slot_reg[wr_ptr_reg] <= in_data;
  end
endmodule // burst_buffer

// >>> core/ddr_sram_device.sv
`timescale 1ns/1ps
`include "sram_link_params.svh"

module ddr_sram_device
  import sram_link_pkg::*;
#(
  parameter int ADDR_W   = `LINK_ADDR_W,
  parameter int BYTE_W   = `LINK_BYTE_W,
  parameter int BYTE_CNT = `LINK_BYTE_CNT,
  parameter int WORD_W   = BYTE_W * BYTE_CNT
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      write_commit,
  sram_link_if.dev  link
);
  // Pipeline geometry
  localparam int PD = `LINK_PIPE_LEN;
  localparam int BL = `LINK_BURST_LEN;
  localparam int WF = `LINK_WR_FIRST;
  localparam int RF = `LINK_RD_FIRST;

  // Previous levels of the input clocks
  logic              k_seen_reg;
  logic              kn_seen_reg;
  // Type of start taken at the last positive rise
  logic              rd_last_reg;
  logic              wr_last_reg;
  // Per-edge history of starts and their addresses
  logic [PD-1:0]     rd_pipe_reg;
  logic [PD-1:0]     wr_pipe_reg;
  logic [ADDR_W-1:0] addr_pipe_reg [PD];
  // Read data output and its enable
  logic [WORD_W-1:0] q_reg;
  logic              q_oe_n_reg;
  // Array write indication
  logic              write_commit_reg;
  // Memory array, one word per address
  logic [WORD_W-1:0] mem [2**ADDR_W];

  // Word selection results
  logic              wr_word_valid;
  logic [ADDR_W-1:0] wr_word_addr;
  logic              rd_word_valid;
  logic [ADDR_W-1:0] rd_word_addr;
  // Merged write word and old contents
  logic [WORD_W-1:0] wr_old;
  logic [WORD_W-1:0] wr_merge;
  logic [WORD_W-1:0] rd_word;

  // Rising edges of each input clock, seen as levels
  wire rise_k  = link.k & ~k_seen_reg;
  wire rise_kn = link.k_n & ~kn_seen_reg;
  wire edge_ev = rise_k | rise_kn;

  // Selects sampled on positive rises only
  // repeat start ignored
  wire rd_sel = rise_k & ~link.read_port_select_n & ~rd_last_reg;
  wire wr_sel = rise_k & ~link.write_port_select_n & ~wr_last_reg;

  wire rd_grant = rd_sel;
  wire wr_grant = wr_sel & ~rd_sel;

  // Any byte lane selected on this data edge
  // no lane, no write
  wire wr_any = ~&link.byte_write_select_n;
  wire wr_do  = edge_ev & wr_word_valid & wr_any;

  // Drive the read port from registers
  assign link.q       = q_reg;
  assign link.q_oe_n  = q_oe_n_reg;
  assign write_commit = write_commit_reg;

  // Clock level history, parked high after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      k_seen_reg  <= 1'h1;
      kn_seen_reg <= 1'h1;
    end else begin
      k_seen_reg  <= link.k;
      kn_seen_reg <= link.k_n;
    end
  end

  // Start history, updated on positive rises
  // same-type select ignored after a start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_last_reg <= 1'h0;
      wr_last_reg <= 1'h0;
    end else if (rise_k) begin
      rd_last_reg <= rd_grant;
      wr_last_reg <= wr_grant;
    end
  end

  // Start pipeline, advances only on clock rises
  // no rises, no change
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pipe_reg <= '0;
      wr_pipe_reg <= '0;
    end else if (edge_ev) begin
      rd_pipe_reg <= {rd_pipe_reg[PD-2:0], rd_grant};
      wr_pipe_reg <= {wr_pipe_reg[PD-2:0], wr_grant};
    end
  end

  // Address pipeline, one stage per entry
  for (genvar i = 0; i < PD; i++) begin : g_addr
    if (i == 0) begin : g_head
      // Latch the address of a start
      always_ff @(posedge sys_clk) begin
        if (edge_ev) addr_pipe_reg[i] <= link.addr;
      end
    end else begin : g_tail
      // Shift along with the start bits
      always_ff @(posedge sys_clk) begin
        if (edge_ev) addr_pipe_reg[i] <= addr_pipe_reg[i-1];
      end
    end
  end

  // Pick the burst word due on this edge
  // word i at address A+i
  always_comb begin
    wr_word_valid = 1'h0;
    wr_word_addr  = '0;
    rd_word_valid = 1'h0;
    rd_word_addr  = '0;
    for (int i = 0; i < BL; i++) begin
      if (wr_pipe_reg[WF-1+i]) begin
        wr_word_valid = 1'h1;
        wr_word_addr  = addr_pipe_reg[WF-1+i] + ADDR_W'(i);
      end
      if (rd_pipe_reg[RF-1+i]) begin
        rd_word_valid = 1'h1;
        rd_word_addr  = addr_pipe_reg[RF-1+i] + ADDR_W'(i);
      end
    end
  end

  // Old contents of the target word
  assign wr_old = mem[wr_word_addr];

  // Per-lane merge of new data into old contents
  for (genvar b = 0; b < BYTE_CNT; b++) begin : g_lane
    assign wr_merge[b*BYTE_W +: BYTE_W] = link.byte_write_select_n[b] ?
                                          wr_old[b*BYTE_W +: BYTE_W] :
                                          link.d[b*BYTE_W +: BYTE_W];
  end

  // Newest data, forwarded from a write on the same edge
  assign rd_word = (wr_do && (wr_word_addr == rd_word_addr)) ? wr_merge : mem[rd_word_addr];

  // Array write, one word per data edge
  always_ff @(posedge sys_clk) begin
    if (wr_do) mem[wr_word_addr] <= wr_merge;
  end

  // Write commit pulse for the user side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_commit_reg <= 1'h0;
    end else begin
      write_commit_reg <= wr_do;
    end
  end

  // Read data output
  // off until a read arrives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_reg      <= '0;
      q_oe_n_reg <= 1'h1;
    end else if (edge_ev) begin
      if (rd_word_valid) begin
        q_reg      <= rd_word;
        q_oe_n_reg <= 1'h0;
      end else begin
        q_oe_n_reg <= 1'h1;
      end
    end
  end
endmodule // ddr_sram_device

// >>> core/sram_controller.sv
`timescale 1ns/1ps
`include "sram_link_params.svh"

module sram_controller
  import sram_link_pkg::*;
#(
  parameter int ADDR_W   = `LINK_ADDR_W,
  parameter int BYTE_W   = `LINK_BYTE_W,
  parameter int BYTE_CNT = `LINK_BYTE_CNT,
  parameter int WORD_W   = BYTE_W * BYTE_CNT,
  parameter int BL       = `LINK_BURST_LEN
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_stop,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_write,
  input  wire logic [ADDR_W-1:0]      cmd_addr,
  input  wire logic [BL*WORD_W-1:0]   cmd_wdata,
  input  wire logic [BL*BYTE_CNT-1:0] cmd_bws_n,
  output logic                        rd_valid,
  output logic      [BL*WORD_W-1:0]   rd_data,
  sram_link_if.ctrl                   link
);
  // One stage more than the device: the device sees each edge a cycle later
  localparam int PD = `LINK_PIPE_LEN + 1;
  localparam int RF = `LINK_RD_FIRST;
  localparam int DW = BL * WORD_W;
  localparam int MW = BL * BYTE_CNT;
  localparam int CW = 1 + ADDR_W + DW + MW;

  // Clock pair state and pins
  link_state_t         state_reg;
  link_state_t         state_next;
  logic                k_reg;
  logic                kn_reg;
  logic                k_next;
  logic                kn_next;
  // Command pins
  logic [ADDR_W-1:0]   addr_reg;
  logic                rps_n_reg;
  logic                wps_n_reg;
  logic [WORD_W-1:0]   d_reg;
  logic [BYTE_CNT-1:0] bws_n_reg;
  // Start history and write slot per edge
  logic                rd_last_reg;
  logic                wr_last_reg;
  logic [PD-1:0]       rd_pipe_reg;
  logic [PD-1:0]       wr_pipe_reg;
  logic [PD-1:0]       slot_pipe_reg;
  logic                wslot_reg;
  logic [DW-1:0]       sdata_reg [2];
  logic [MW-1:0]       sbws_reg  [2];
  // Read assembly and result
  logic [DW-1:0]       acc_reg;
  logic                rd_valid_reg;
  logic [DW-1:0]       rd_data_reg;
  // Buffer output side
  logic                buf_valid;
  logic [CW-1:0]       buf_data;
  // Start taken from the buffer on this edge
  logic                launch;
  // Next data word selection
  logic [WORD_W-1:0]   d_next;
  logic [BYTE_CNT-1:0] bws_next;

  // Command buffer, stalls the user while full
  burst_buffer #(.WIDTH(CW), .DEPTH(`LINK_BUF_DEPTH)) u_cmd_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_write, cmd_addr, cmd_wdata, cmd_bws_n}),
    .out_valid (buf_valid),
    .out_ready (launch),
    .out_data  (buf_data)
  );

  // Buffer fields
  wire               buf_write = buf_data[CW-1];
  wire [ADDR_W-1:0]  buf_addr  = buf_data[DW+MW +: ADDR_W];

  // Park only with no burst in flight
  // park both high
  wire idle = ~|{rd_pipe_reg, wr_pipe_reg};
  assign state_next = (clk_stop && (idle || state_reg == LINK_PARKED)) ? LINK_PARKED : LINK_RUN;
  // Parked pair is high; restart drops the positive clock first
  wire parked_now = k_reg & kn_reg;
  assign k_next  = (state_next == LINK_PARKED) ? 1'h1 : (parked_now ? 1'h0 : ~k_reg);
  assign kn_next = (state_next == LINK_PARKED) ? 1'h1 : (parked_now ? 1'h1 : ~kn_reg);
  wire gen_krise = k_next & ~k_reg;
  wire gen_edge  = gen_krise | (kn_next & ~kn_reg);

  // Start only on a positive rise, never the same type twice running
  // no back-to-back type
  wire launch_ok = gen_krise & (state_next == LINK_RUN) & buf_valid;
  assign launch  = launch_ok & (buf_write ? ~wr_last_reg : ~rd_last_reg);
  wire launch_rd = launch & ~buf_write;
  wire launch_wr = launch & buf_write;

  // Pins from registers
  assign link.k                   = k_reg;
  assign link.k_n                 = kn_reg;
  assign link.addr                = addr_reg;
  assign link.read_port_select_n  = rps_n_reg;
  assign link.write_port_select_n = wps_n_reg;
  assign link.d                   = d_reg;
  assign link.byte_write_select_n = bws_n_reg;
  assign rd_valid                 = rd_valid_reg;
  assign rd_data                  = rd_data_reg;

  // Write word due on the next data edge, device takes it on that same edge a cycle later
  // words on edges 2..5
  always_comb begin
    d_next   = '0;
    bws_next = '1;
    for (int i = 0; i < BL; i++) begin
      if (wr_pipe_reg[i+1]) begin
        d_next   = sdata_reg[slot_pipe_reg[i+1]][i*WORD_W +: WORD_W];
        bws_next = sbws_reg[slot_pipe_reg[i+1]][i*BYTE_CNT +: BYTE_CNT];
      end
    end
  end

  // Clock generation and command pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= LINK_PARKED;
      k_reg     <= 1'h1;
      kn_reg    <= 1'h1;
      rps_n_reg <= 1'h1;
      wps_n_reg <= 1'h1;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      k_reg     <= k_next;
      kn_reg    <= kn_next;
      rps_n_reg <= ~launch_rd;
      wps_n_reg <= ~launch_wr;
      if (launch) addr_reg <= buf_addr;
    end
  end

  // Start history and pipelines
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_last_reg   <= 1'h0;
      wr_last_reg   <= 1'h0;
      rd_pipe_reg   <= '0;
      wr_pipe_reg   <= '0;
      slot_pipe_reg <= '0;
      wslot_reg     <= 1'h0;
      d_reg         <= '0;
      bws_n_reg     <= '1;
    end else begin
      if (gen_krise) begin
        rd_last_reg <= launch_rd;
        wr_last_reg <= launch_wr;
      end
      if (gen_edge) begin
        rd_pipe_reg   <= {rd_pipe_reg[PD-2:0], launch_rd};
        wr_pipe_reg   <= {wr_pipe_reg[PD-2:0], launch_wr};
        slot_pipe_reg <= {slot_pipe_reg[PD-2:0], wslot_reg};
        d_reg         <= d_next;
        bws_n_reg     <= bws_next;
      end
      if (launch_wr) wslot_reg <= ~wslot_reg;
    end
  end

  // Hold write burst data for its slot
  always_ff @(posedge sys_clk) begin
    if (launch_wr) begin
      sdata_reg[wslot_reg] <= buf_data[MW +: DW];
      sbws_reg[wslot_reg]  <= buf_data[MW-1:0];
    end
  end

  // Read word capture, one per data edge
  for (genvar i = 0; i < BL; i++) begin : g_cap
    always_ff @(posedge sys_clk) begin
      if (gen_edge && rd_pipe_reg[RF+1+i]) acc_reg[i*WORD_W +: WORD_W] <= link.q;
    end
  end

  // Whole burst result, one-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid_reg <= 1'h0;
      rd_data_reg  <= '0;
    end else begin
      rd_valid_reg <= gen_edge & rd_pipe_reg[RF+BL];
      if (gen_edge && rd_pipe_reg[RF+BL]) rd_data_reg <= {link.q, acc_reg[DW-WORD_W-1:0]};
    end
  end
endmodule // sram_controller

// >>> testbench/sram_link_checker.sv
`timescale 1ns/1ps

module sram_link_checker #(
  parameter int ADDR_W   = 6,
  parameter int WORD_W   = 18,
  parameter int BYTE_CNT = 2
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                k,
  input wire logic                k_n,
  input wire logic [ADDR_W-1:0]   addr,
  input wire logic                read_port_select_n,
  input wire logic                write_port_select_n,
  input wire logic [WORD_W-1:0]   d,
  input wire logic [BYTE_CNT-1:0] byte_write_select_n,
  input wire logic [WORD_W-1:0]   q,
  input wire logic                q_oe_n
);
  // Positive clock level one cycle back
  logic       k_prev_reg;
  // Read starts, bit n is n+1 cycles ago
  logic [8:0] rd_hist_reg;
  // Start decode on a positive rise
  wire        k_rise   = k & ~k_prev_reg;
  wire        rd_start = k_rise & ~read_port_select_n;
  wire        wr_start = k_rise & ~write_port_select_n;
  wire        parked   = k & k_n;

  // History of clock and read starts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      k_prev_reg  <= 1'b1;
      rd_hist_reg <= '0;
    end else begin
      k_prev_reg  <= k;
      rd_hist_reg <= {rd_hist_reg[7:0], rd_start};
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_park;
    $past(rst) |-> parked && read_port_select_n && write_port_select_n && q_oe_n;
  endproperty
  a_reset_park: assert property (p_reset_park)
    else $error("link not parked after reset");
  property p_rd_window;
    rd_start |-> ##6 !q_oe_n [*4];
  endproperty
  a_rd_window: assert property (p_rd_window)
    else $error("read words not driven in their window");
  property p_oe_cause;
    !q_oe_n |-> |rd_hist_reg[8:5];
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("read data driven with no read due");
  property p_k_pair;
    k || k_n;
  endproperty
  a_k_pair: assert property (p_k_pair)
    else $error("both input clocks low");
  property p_park_hold;
    parked && $past(parked) && $past(parked, 2) |-> $stable(q_oe_n) && $stable(q);
  endproperty
  a_park_hold: assert property (p_park_hold)
    else $error("outputs moved while clocks parked");
  property p_no_rd_back;
    rd_start |-> ##2 !rd_start;
  endproperty
  a_no_rd_back: assert property (p_no_rd_back)
    else $error("reads on consecutive rises");
  property p_no_wr_back;
    wr_start |=> !wr_start [*3];
  endproperty
  a_no_wr_back: assert property (p_no_wr_back)
    else $error("writes on consecutive rises");
  property p_no_both;
    k_rise |-> read_port_select_n || write_port_select_n;
  endproperty
  a_no_both: assert property (p_no_both)
    else $error("both port selects low on one rise");

  // Main scenarios seen
  c_read: cover property (rd_start);
  c_write: cover property (wr_start);
  c_wr_rd: cover property (wr_start ##2 rd_start);
  c_park: cover property (parked [*8]);
endmodule // sram_link_checker

// >>> testbench/ddr_sram_burst_port_protocol_tb.sv
`timescale 1ns/1ps

module ddr_sram_burst_port_protocol_tb;
  localparam int AW = 6;
  // Clock, reset and controller user side
  logic        sys_clk;
  logic        rst;
  logic        clk_stop;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic [5:0]  cmd_addr;
  logic [71:0] cmd_wdata;
  logic [7:0]  cmd_bws_n;
  logic        rd_valid;
  logic [71:0] rd_data;
  logic        commit1;
  logic        commit2;
  // Bench bookkeeping
  int          miscompares;
  int          checks;
  int          commits;
  int          saw_full;
  logic [71:0] e;
  logic [71:0] n;
  logic [71:0] r;

  sram_link_if #(.ADDR_W(AW)) link ();
  // Second link, driven by the bench to break rules
  sram_link_if #(.ADDR_W(AW)) link2 ();

  sram_controller #(.ADDR_W(AW)) sram_controller_i (.sys_clk(sys_clk), .rst(rst), .clk_stop(clk_stop),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_bws_n(cmd_bws_n), .rd_valid(rd_valid), .rd_data(rd_data), .link(link));
  ddr_sram_device #(.ADDR_W(AW)) ddr_sram_device_i (.sys_clk(sys_clk), .rst(rst), .write_commit(commit1),
    .link(link));
  ddr_sram_device #(.ADDR_W(AW)) ddr_sram_device_i2 (.sys_clk(sys_clk), .rst(rst), .write_commit(commit2),
    .link(link2));
  sram_link_checker #(.ADDR_W(AW)) sram_link_checker_i (.sys_clk(sys_clk), .rst(rst), .k(link.k),
    .k_n(link.k_n), .addr(link.addr), .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n), .d(link.d), .byte_write_select_n(link.byte_write_select_n),
    .q(link.q), .q_oe_n(link.q_oe_n));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Count words landed and flag refused offers
  always @(posedge sys_clk) if (commit1 === 1'b1) commits++;
  always @(negedge sys_clk) if (cmd_valid && cmd_ready === 1'b0) saw_full = 1;

  // Four words, word i distinct per address and seed
  function automatic logic [71:0] burst(input int a, input int s);
    logic [71:0] v;
    for (int i = 0; i < 4; i++) v[i*18+:18] = 18'(a * 37 + i * 5 + s * 131);
    return v;
  endfunction

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offer one command and hold it until taken
  task automatic send(input logic w, input logic [5:0] a, input logic [71:0] wd, input logic [7:0] bw);
    int t;
    t = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_bws_n = bw;
    while (cmd_ready !== 1'b1 && t < 100) begin
      @(negedge sys_clk);
      t++;
    end
    if (t == 100) miscompares++;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask

  // Wait for one read result
  task automatic get_read(output logic [71:0] res);
    int t;
    t = 0;
    while (rd_valid !== 1'b1 && t < 200) begin
      @(negedge sys_clk);
      t++;
    end
    if (t == 200) miscompares++;
    res = rd_data;
    @(negedge sys_clk);
  endtask

  task automatic read_chk(input logic [5:0] a, input logic [71:0] exp);
    logic [71:0] res;
    send(1'b0, a, 72'h0, 8'hFF);
    get_read(res);
    check(res, exp);
  endtask

  // Drive the second link directly: rm/wm select low per cycle
  task automatic fault_run(input logic [23:0] rm, input logic [23:0] wm, input int eo, input int ew);
    int oe;
    int wc;
    oe = 0;
    wc = 0;
    link2.byte_write_select_n = 2'h0;
    for (int i = 0; i < 24; i++) begin
      @(negedge sys_clk);
      if (link2.q_oe_n === 1'b0) oe++;
      if (commit2 === 1'b1) wc++;
      link2.k = i[0];
      link2.k_n = ~i[0];
      link2.read_port_select_n = ~rm[i];
      link2.write_port_select_n = ~wm[i];
    end
    @(negedge sys_clk);
    link2.k_n = 1'b1;
    check(72'(oe), 72'(eo));
    check(72'(wc), 72'(ew));
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    clk_stop = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 6'h0;
    cmd_wdata = 72'h0;
    cmd_bws_n = 8'hFF;
    link2.k = 1'b1;
    link2.k_n = 1'b1;
    link2.addr = 6'h0;
    link2.d = 18'h0;
    link2.byte_write_select_n = 2'h3;
    link2.read_port_select_n = 1'b1;
    link2.write_port_select_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    check(72'({link.k, link.k_n, link.q_oe_n, link2.q_oe_n}), 72'hF);
    $display("test reset done");
    send(1'b1, 6'h08, burst(8, 1), 8'h00);
    read_chk(6'h08, burst(8, 1));
    $display("test burst done");
    send(1'b1, 6'h04, burst(4, 2), 8'h00);
    read_chk(6'h04, burst(4, 2));
    commits = 0;
    e = burst(4, 2);
    n = burst(4, 3);
    e[17:0] = n[17:0];
    e[35:27] = n[35:27];
    e[44:36] = n[44:36];
    send(1'b1, 6'h04, n, 8'hE4);
    read_chk(6'h04, e);
    check(72'(commits), 72'h3);
    $display("test lanes done");
    send(1'b1, 6'h3E, burst(62, 4), 8'h00);
    read_chk(6'h3E, burst(62, 4));
    send(1'b0, 6'h00, 72'h0, 8'hFF);
    get_read(r);
    e = burst(62, 4);
    check(72'(r[35:0]), 72'(e[71:36]));
    $display("test wrap done");
    clk_stop = 1'b1;
    repeat (30) @(negedge sys_clk);
    check(72'({link.k, link.k_n, link.q_oe_n}), 72'h7);
    clk_stop = 1'b0;
    read_chk(6'h08, burst(8, 1));
    $display("test park done");
    saw_full = 0;
    for (int i = 0; i < 6; i++) send(1'b1, 6'(16 + 4 * i), burst(16 + 4 * i, 5), 8'h00);
    check(72'(saw_full), 72'h1);
    for (int i = 0; i < 6; i++) read_chk(6'(16 + 4 * i), burst(16 + 4 * i, 5));
    $display("test fill done");
    fault_run(24'h00000A, 24'h000000, 4, 0);
    fault_run(24'h000000, 24'h00000A, 0, 4);
    fault_run(24'h00000A, 24'h00000A, 4, 4);
    fault_run(24'h000000, 24'h000000, 0, 0);
    $display("test faults done");
    print_verdict();
  end
endmodule // ddr_sram_burst_port_protocol_tb
